// ==== dv/strap_board_model.sv ====
// Board-side model that sets the strap pins the way a careful system would.
// Assumes the bench gives the wanted levels and whether external termination exists.
`timescale 1ns/1ns
module strap_board_model (
    input  wire       aclk,
    input  wire [1:0] want_source,
    input  wire       want_eq,
    input  wire       want_int_term,
    input  wire       ext_term,
    input  wire [1:0] want_pe,
    output reg  [1:0] strap_source_select,
    output reg        strap_equalizer_level,
    output reg        strap_output_term_on,
    output reg        strap_output_enable,
    output reg        strap_output_current_level,
    output reg  [1:0] strap_preemphasis_level
);
    initial {strap_source_select, strap_equalizer_level, strap_output_term_on} = 4'h0;
    initial {strap_output_enable, strap_output_current_level, strap_preemphasis_level} = 4'h0;
    always @(posedge aclk) begin
        strap_source_select        <= want_source;
        strap_equalizer_level      <= want_eq;
        strap_output_term_on       <= want_int_term;
        strap_preemphasis_level    <= want_pe;
        strap_output_current_level <= want_int_term & ext_term;
        strap_output_enable        <= want_int_term | ext_term;
    end
endmodule // strap_board_model

// ==== dv/test_video_switch_config_control.sv ====
// Self-checking bench for the video switch configuration block.
// Assumes AXI4-Lite access and straps set through the board model.
`timescale 1ns/1ns
`include "video_switch_defines.vh"
module test_video_switch_config_control;
    reg         aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    reg  [7:0]  awaddr, araddr;
    reg  [31:0] wdata, rd;
    reg  [1:0]  w_src, w_pe, rr;
    reg         w_eq, w_term, w_ext;
    wire        awready, wready, bvalid, arready, rvalid, sm, ot, oc, oe;
    wire [1:0]  bresp, rresp, s_src, s_pe, src, pe;
    wire [31:0] rdata;
    wire [6:0]  baddr;
    wire [7:0]  eq;
    wire [15:0] tc;
    wire        s_eq, s_ot, s_oe, s_oc;
    integer     fail_count, comparisons, i;
    strap_board_model brd_u (.aclk(aclk), .want_source(w_src), .want_eq(w_eq), .want_int_term(w_term),
        .ext_term(w_ext), .want_pe(w_pe), .strap_source_select(s_src), .strap_equalizer_level(s_eq),
        .strap_output_term_on(s_ot), .strap_output_enable(s_oe), .strap_output_current_level(s_oc),
        .strap_preemphasis_level(s_pe));
    video_switch_config_control #(.BUS_ADDRESS_SELECT(3'h5), .TERM_PULSE_CYCLES(24'd20)) dut_u (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .strap_source_select(s_src),
        .strap_equalizer_level(s_eq), .strap_output_term_on(s_ot), .strap_output_enable(s_oe),
        .strap_output_current_level(s_oc), .strap_preemphasis_level(s_pe), .bus_address(baddr),
        .source_select(src), .input_equalizer_level(eq), .input_term_connect(tc), .output_term_on(ot),
        .output_current_level(oc), .output_preemphasis_level(pe), .highspeed_output_enable(oe),
        .serial_mode(sm));
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    task report_and_stop;
        begin
            $display("checks %0d mismatches %0d", comparisons, fail_count);
            if (fail_count == 0 && comparisons > 0) $display("verification passed");
            else $display("verification failed");
            $finish;
        end
    endtask
    task check(input [31:0] seen, input [31:0] exp, input string what);
        begin
            comparisons = comparisons + 1;
            if (seen !== exp) begin
                fail_count = fail_count + 1;
                $display("ERROR %s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    task pause(input integer n);
        repeat (n) @(posedge aclk);
    endtask
    task do_reset;
        begin
            @(posedge aclk);
            aresetn <= 1'b0;
            pause(12);
            aresetn <= 1'b1;
            pause(40);
        end
    endtask
    task wr(input [7:0] a, input [31:0] d, input [1:0] er);
        reg aw_ok, w_ok;
        begin
            @(posedge aclk);
            {aw_ok, w_ok} = 2'b00;
            awaddr <= a;
            wdata <= d;
            {awvalid, wvalid, bready} <= 3'b111;
            while (!(aw_ok && w_ok)) begin
                @(posedge aclk);
                if (awvalid && awready) begin aw_ok = 1'b1; awvalid <= 1'b0; end
                if (wvalid && wready) begin w_ok = 1'b1; wvalid <= 1'b0; end
            end
            do @(posedge aclk); while (!bvalid);
            check(bresp, er, "bresp");
            bready <= 1'b0;
        end
    endtask
    task rd_reg(input [7:0] a);
        begin
            @(posedge aclk);
            araddr <= a;
            {arvalid, rready} <= 2'b11;
            do @(posedge aclk); while (!arready);
            arvalid <= 1'b0;
            while (!rvalid) @(posedge aclk);
            rd = rdata;
            rr = rresp;
            rready <= 1'b0;
        end
    endtask
    initial begin
        repeat (4000) @(posedge aclk);
        fail_count = fail_count + 1;
        report_and_stop;
    end
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
        {awaddr, araddr, wdata} = 48'h0;
        fail_count = 0;
        comparisons = 0;
        {w_src, w_eq, w_term, w_ext, w_pe} = 7'b10_1_1_1_11;
        do_reset;
        check(baddr, {`BUS_ADDR_BASE, 3'h5}, "address");
        check({src, eq, ot, oc, pe, oe}, {2'h2, 8'hff, 5'h1f}, "strap set");
        check({tc, sm}, {16'hffff, 1'b0}, "strap term");
        {w_src, w_eq, w_pe} <= 5'b01_0_00;
        pause(5);
        do_reset;
        check({src, eq, pe}, {2'h1, 8'h00, 2'h0}, "strap reload");
        rd_reg(`REG_SOURCE);
        check({rr, rd[29:0]}, {2'h0, 30'h1}, "source reg default");
        check(sm, 1'b1, "serial mode");
        w_eq <= 1'b1;
        pause(40);
        check(eq, 8'h00, "straps ignored");
        wr(`REG_RX_EQUALIZER, 32'ha5, `RESP_OKAY);
        pause(25);
        check(eq, 8'ha5, "equalizer");
        for (i = 0; i < 4; i = i + 1) begin
            wr(`REG_TX_SETTINGS, (i << `OUTPUT_PREEMPHASIS_LEVEL_LSB) | 1, `RESP_OKAY);
            pause(25);
            check({pe, ot, oc}, {i[1:0], 2'b10}, "preemphasis");
        end
        wr(`REG_TX_SETTINGS, 32'h2, `RESP_OKAY);
        pause(25);
        check({ot, oc}, 2'b01, "term and current");
        wr(`REG_HS_MODES, 32'h0, `RESP_OKAY);
        pause(25);
        check(oe, 1'b0, "output off");
        wr(`REG_HS_MODES, 32'h1, `RESP_OKAY);
        wr(`REG_RX_SETTINGS, 32'h1, `RESP_OKAY);
        pause(25);
        check({oe, tc}, {1'b1, 16'h0000}, "global off");
        wr(`REG_RX_SETTINGS, 32'h0, `RESP_OKAY);
        wr(`REG_TERM_PULSE, 32'h00f0, `RESP_OKAY);
        wr(`REG_SOURCE, 32'h3, `RESP_OKAY);
        pause(26);
        check(tc, 16'hff0f, "term pulse");
        pause(30);
        check({src, tc}, {2'h3, 16'hffff}, "pulse end");
        wr(`REG_SOURCE, 32'h0, `RESP_OKAY);
        pause(10);
        wr(`REG_SOURCE, 32'h2, `RESP_OKAY);
        pause(12);
        check(src, 2'h2, "window not restarted");
        wr(8'h40, 32'h1, `RESP_DECERR);
        rd_reg(8'h40);
        check(rr, `RESP_DECERR, "unmapped read");
        rd_reg(`REG_STATUS);
        check(rd[2:0], 3'b101, "status mode");
        w_term <= 1'b0;
        do_reset;
        check({sm, src, eq, tc}, {1'b0, 2'h1, 8'hff, 16'hffff}, "reset restore");
        check({ot, oc}, 2'b00, "external only current");
        check(oe, 1'b1, "enabled with external term");
        report_and_stop;
    end
endmodule // test_video_switch_config_control

// ==== dv/video_switch_config_control_sva.sv ====
// Assertion checker for the video switch configuration block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ns
`include "video_switch_defines.vh"
module video_switch_config_control_sva #(
    parameter [2:0] BUS_ADDRESS_SELECT = 3'h0
) (
    input wire        aclk,
    input wire        aresetn,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire [6:0]  bus_address,
    input wire [15:0] input_term_connect,
    input wire        serial_mode
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_bus_address_fixed: assert property (bus_address == {`BUS_ADDR_BASE, BUS_ADDRESS_SELECT})
        else $error("bus address differs from base and select");
    a_reset_defaults: assert property (disable iff (1'b0) !aresetn |=> input_term_connect == 16'hffff && !serial_mode)
        else $error("reset left terminations or mode wrong");
    a_serial_sticky: assert property (serial_mode |=> serial_mode)
        else $error("serial mode dropped without reset");
    a_read_enters_serial: assert property (s_axi_rvalid && s_axi_rready |=> serial_mode)
        else $error("read did not enter serial mode");
    a_strap_term_on: assert property (!serial_mode |-> input_term_connect == 16'hffff)
        else $error("termination cut under strap control");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> ##1 s_axi_bvalid) else $error("write response late");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response not held");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    a_write_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    c_write_done: cover property (s_axi_bvalid && s_axi_bready);
    c_serial_entry: cover property ($rose(serial_mode));
    c_term_pulse: cover property (serial_mode ##1 input_term_connect != 16'hffff);
endmodule // video_switch_config_control_sva
bind video_switch_config_control video_switch_config_control_sva #(.BUS_ADDRESS_SELECT(BUS_ADDRESS_SELECT)) chk_u (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .s_axi_rready, .bus_address, .input_term_connect, .serial_mode);

// ==== verilog/settings_store.v ====
// Holding register of applied settings, loaded at the end of an update window.
// Assumes the load strobe is on the same clock as the data.
`timescale 1ns/1ns
module settings_store #(
    parameter WIDTH = 40
) (
    input  wire             aclk,
    input  wire             aresetn,
    input  wire             load,
    input  wire [WIDTH-1:0] wdata,
    output reg  [WIDTH-1:0] rdata
);
    // Applied state clears under reset and follows the staged value on load.
    always @(posedge aclk) begin
        if (!aresetn) begin
            rdata <= {WIDTH{1'b0}};
        end else if (load) begin
            rdata <= wdata;
        end
    end
endmodule // settings_store

// ==== verilog/video_switch_config_control.v ====
// Configuration and control logic of a four-input, one-output video link switch.
// Assumes strap pins are asynchronous and the register bus is AXI4-Lite on aclk.
`timescale 1ns/1ns
`include "video_switch_defines.vh"
// Operation
// - Route one of four sources to output.
// - Treat all four channels of a link alike; code has one pulse enable bit per channel.
// - Answer on one of eight bus addresses.
// - Reset returns control registers to defaults.
// - Serial access overrides straps until reset.
// - Enabled inputs lose termination for 100 ms after switch.
// - Global off bit disconnects every input termination.
// - Input terminations connected after reset.
// - Strap control keeps all terminations connected.
// - Per-channel 6 or 12 dB equalizer bits.
// - Strap equalizer pin sets all eight channels.
// - Output termination by bit or strap.
// - Output enable control tristates high-speed outputs.
// - Output termination resets from strap pin.
// - Output current resets from strap pin.
// - Four pre-emphasis levels by field or straps.
// - Strap pair selects the routed source.
// - Reset defaults equal current strap levels.
// - Writes in update window do not restart it.
module video_switch_config_control #(
    parameter [2:0]  BUS_ADDRESS_SELECT  = 3'h0,
    parameter [23:0] TERM_PULSE_CYCLES   = `TERM_PULSE_CYCLES,
    parameter [7:0]  UPDATE_DELAY_CYCLES = `UPDATE_DELAY_CYCLES
) (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire [1:0]  strap_source_select,
    input  wire        strap_equalizer_level,
    input  wire        strap_output_term_on,
    input  wire        strap_output_enable,
    input  wire        strap_output_current_level,
    input  wire [1:0]  strap_preemphasis_level,
    output wire [6:0]  bus_address,
    output reg  [1:0]  source_select,
    output reg  [7:0]  input_equalizer_level,
    output reg  [15:0] input_term_connect,
    output reg         output_term_on,
    output reg         output_current_level,
    output reg  [1:0]  output_preemphasis_level,
    output reg         highspeed_output_enable,
    output reg         serial_mode
);
    reg  [7:0]  strap_meta;
    reg  [7:0]  strap_sync;
    reg         after_reset;
    reg  [1:0]  reg_source;
    reg         reg_hs_enable;
    reg         input_term_global_off;
    reg  [7:0]  reg_equalizer;
    reg  [15:0] input_term_pulse_enable;
    reg         reg_term_on;
    reg         reg_current;
    reg  [1:0]  reg_preemphasis;
    reg  [7:0]  window_count;
    reg  [23:0] pulse_count;
    reg  [1:0]  applied_source_d;
    reg         aw_held;
    reg         w_held;
    reg  [7:0]  aw_addr;
    reg  [31:0] w_data;
    reg  [3:0]  w_strb;
    reg  [7:0]  next_rdata;
    reg         next_rvalid_ok;
    wire        do_write;
    wire [7:0]  wbyte;
    wire [39:0] staged;
    wire [39:0] applied;
    wire        window_open;
    wire        pulse_active;
    wire [1:0]  strap_src;
    wire        strap_eq;
    wire        strap_oto;
    wire        strap_en;
    wire        strap_ocl;
    wire [1:0]  strap_pe;
    genvar      ch;

    assign bus_address = {`BUS_ADDR_BASE, BUS_ADDRESS_SELECT};
    assign strap_src   = strap_sync[1:0];
    assign strap_eq    = strap_sync[2];
    assign strap_oto   = strap_sync[3];
    assign strap_en    = strap_sync[4];
    assign strap_ocl   = strap_sync[5];
    assign strap_pe    = strap_sync[7:6];

    // Straps pass two flip-flops before use.
    always @(posedge aclk) begin
        if (!aresetn) begin
            strap_meta <= 8'h00;
            strap_sync <= 8'h00;
        end else begin
            strap_meta <= {strap_preemphasis_level, strap_output_current_level, strap_output_enable,
                           strap_output_term_on, strap_equalizer_level, strap_source_select};
            strap_sync <= strap_meta;
        end
    end

    // Write channel: address and data are taken in either order.
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign do_write      = aw_held && w_held;
    assign wbyte         = w_data[7:0];

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            aw_addr      <= 8'h00;
            w_data       <= 32'h00000000;
            w_strb       <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                case (aw_addr)
                    `REG_SOURCE, `REG_HS_MODES, `REG_RX_SETTINGS, `REG_RX_EQUALIZER,
                    `REG_TERM_PULSE, `REG_TX_SETTINGS, `REG_STATUS: s_axi_bresp <= `RESP_OKAY;
                    default: s_axi_bresp <= `RESP_DECERR;
                endcase
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Serial registers: first access of any kind after the first cycle out of reset switches to serial mode.
    always @(posedge aclk) begin
        if (!aresetn) begin
            serial_mode             <= 1'b0;
            after_reset             <= 1'b1;
            reg_source              <= 2'h0;
            reg_hs_enable           <= 1'b0;
            input_term_global_off   <= 1'b0;
            reg_equalizer           <= 8'h00;
            input_term_pulse_enable <= 16'h0000;
            reg_term_on             <= 1'b0;
            reg_current             <= 1'b0;
            reg_preemphasis         <= 2'h0;
        end else begin
            after_reset <= 1'b0;
            if (after_reset || !serial_mode) begin
                // Defaults track strap levels until serial mode begins.
                reg_source      <= strap_src;
                reg_hs_enable   <= strap_en;
                reg_equalizer   <= {8{strap_eq}};
                reg_term_on     <= strap_oto;
                reg_current     <= strap_ocl;
                reg_preemphasis <= strap_pe;
            end
            if ((do_write || (s_axi_arvalid && s_axi_arready)) && !after_reset) begin
                serial_mode <= 1'b1;
            end
            if (do_write && w_strb[0] && !after_reset) begin
                case (aw_addr)
                    `REG_SOURCE:       reg_source <= wbyte[1:0];
                    `REG_HS_MODES:     reg_hs_enable <= wbyte[0];
                    `REG_RX_SETTINGS:  input_term_global_off <= wbyte[0];
                    `REG_RX_EQUALIZER: reg_equalizer <= wbyte;
                    `REG_TX_SETTINGS: begin
                        reg_term_on     <= wbyte[`TX_TERM_BIT];
                        reg_current     <= wbyte[`OUTPUT_CURRENT_LEVEL_BIT];
                        reg_preemphasis <= wbyte[`OUTPUT_PREEMPHASIS_LEVEL_LSB+1:`OUTPUT_PREEMPHASIS_LEVEL_LSB];
                    end
                    default: ;
                endcase
            end
            if (do_write && !after_reset && aw_addr == `REG_TERM_PULSE) begin
                if (w_strb[0]) input_term_pulse_enable[7:0]  <= w_data[7:0];
                if (w_strb[1]) input_term_pulse_enable[15:8] <= w_data[15:8];
            end
        end
    end

    // Read channel: one read at a time, answer one cycle after address.
    assign s_axi_arready = !s_axi_rvalid;
    always @* begin
        next_rdata     = 8'h00;
        next_rvalid_ok = 1'b1;
        case (s_axi_araddr)
            `REG_SOURCE:       next_rdata = {6'h00, reg_source};
            `REG_HS_MODES:     next_rdata = {7'h00, reg_hs_enable};
            `REG_RX_SETTINGS:  next_rdata = {7'h00, input_term_global_off};
            `REG_RX_EQUALIZER: next_rdata = reg_equalizer;
            `REG_TERM_PULSE:   next_rdata = 8'h00;
            `REG_TX_SETTINGS:  next_rdata = {4'h0, reg_preemphasis, reg_current, reg_term_on};
            `REG_STATUS:       next_rdata = {5'h00, pulse_active, window_open, serial_mode};
            default:           next_rvalid_ok = 1'b0;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= next_rvalid_ok ? `RESP_OKAY : `RESP_DECERR;
            if (s_axi_araddr == `REG_TERM_PULSE) begin
                s_axi_rdata <= {16'h0000, input_term_pulse_enable};
            end else begin
                s_axi_rdata <= {24'h000000, next_rdata};
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Update window: a change opens it, later writes do not restart it.
    assign staged      = {reg_source, reg_hs_enable, input_term_global_off, reg_equalizer, 4'h0,
                          input_term_pulse_enable, reg_term_on, reg_current, reg_preemphasis, serial_mode,
                          2'h0, after_reset};
    assign window_open = (window_count != 8'h00);
    always @(posedge aclk) begin
        if (!aresetn) begin
            window_count <= 8'h00;
        end else if (window_open) begin
            window_count <= window_count - 8'h01;
        end else if (staged != applied) begin
            window_count <= UPDATE_DELAY_CYCLES;
        end
    end

    settings_store #(
        .WIDTH(40)
    ) u_applied (
        .aclk    (aclk),
        .aresetn (aresetn),
        .load    (window_count == 8'h01),
        .wdata   (staged),
        .rdata   (applied)
    );

    // Termination pulse counter, preset on each applied source switch.
    assign pulse_active = (pulse_count != 24'h000000);
    always @(posedge aclk) begin
        if (!aresetn) begin
            pulse_count      <= 24'h000000;
            applied_source_d <= 2'h0;
        end else begin
            applied_source_d <= applied[39:38];
            if (applied[39:38] != applied_source_d) begin
                pulse_count <= TERM_PULSE_CYCLES;
            end else if (pulse_active) begin
                pulse_count <= pulse_count - 24'h000001;
            end
        end
    end

    // Applied outputs, registered.
    always @(posedge aclk) begin
        if (!aresetn) begin
            source_select            <= 2'h0;
            output_term_on           <= 1'b0;
            output_current_level     <= 1'b0;
            output_preemphasis_level <= 2'h0;
            highspeed_output_enable  <= 1'b0;
        end else begin
            source_select            <= applied[39:38];
            highspeed_output_enable  <= applied[37];
            output_term_on           <= applied[7];
            output_current_level     <= applied[6];
            output_preemphasis_level <= applied[5:4];
        end
    end

    // Per-input termination and per-channel equalizer, same logic for every lane.
    generate
        for (ch = 0; ch < 16; ch = ch + 1) begin : g_term
            always @(posedge aclk) begin
                if (!aresetn) begin
                    input_term_connect[ch] <= 1'b1;
                end else if (!applied[3]) begin
                    input_term_connect[ch] <= 1'b1;
                end else begin
                    input_term_connect[ch] <= !applied[36] &&
                        !(applied[8 + ch] && pulse_active);
                end
            end
        end
        for (ch = 0; ch < 8; ch = ch + 1) begin : g_eq
            always @(posedge aclk) begin
                if (!aresetn) begin
                    input_equalizer_level[ch] <= 1'b0;
                end else begin
                    input_equalizer_level[ch] <= applied[28 + ch];
                end
            end
        end
    endgenerate
endmodule // video_switch_config_control

// ==== verilog/video_switch_defines.vh ====
// Constants for the video switch configuration and control block.
// Assumes a 10 MHz control clock and a 32-bit AXI4-Lite register bus.
`ifndef VIDEO_SWITCH_DEFINES_VH
`define VIDEO_SWITCH_DEFINES_VH
`define CLK_PERIOD_NS        100
`define TERM_PULSE_MS        100
`define TERM_PULSE_CYCLES    ((`TERM_PULSE_MS * 1000000) / `CLK_PERIOD_NS)
`define UPDATE_DELAY_CYCLES  16
`define BUS_ADDR_BASE        4'h9
`define REG_SOURCE           8'h00
`define REG_HS_MODES         8'h04
`define REG_RX_SETTINGS      8'h08
`define REG_RX_EQUALIZER     8'h0c
`define REG_TERM_PULSE       8'h10
`define REG_TX_SETTINGS      8'h14
`define REG_STATUS           8'h18
`define TX_TERM_BIT          0
`define OUTPUT_CURRENT_LEVEL_BIT           1
`define OUTPUT_PREEMPHASIS_LEVEL_LSB            2
`define RESP_OKAY            2'b00
`define RESP_DECERR          2'b11
`endif
